// [src/pps_sequencer.sv]
/*
  Pushbutton power sequencer: debounce, enable decision, channel
  ordering, switched output, processor reset timing, Avalon-MM registers.
  Assumes all inputs synchronous to clk; analog parts sit outside.
*/
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
// Overview of operation
// - hold high or button low enables device
// - fixed order: step-down one, two, buck-boost
// - press accepted after 24ms low debounce
// - debounced press: status low, start channel one
// - channel two waits for channel one good
// - buck-boost waits for channel two good
// - buck-boost good: switch on, timer starts
// - reset held until timer reaches terminal count
// - button released, hold low: disable, discharge
// - undriven hold input reads low
// - undriven pushbutton reads high, not pressed
// - standby keeps all sequenced outputs off
// - disabled channel skipped, next starts at once
// - all enables low at start: manual mode
// - manual enables start converters together, ungated
// - converters timed from one 1.27MHz tick
// - one mode input sets all converters' mode
// - mode high fixed frequency, low allows burst
// - reset asserted during fault and when disabled
// - power-good loss clears timer, asserts reset
`timescale 1ns/1ps
module pps_sequencer
#(
  parameter int DEBOUNCE_TICKS = pps_pkg::DEBOUNCE_TICKS
)
(
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic                     power_hold_in,
  input  wire logic                     power_hold_driven,
  input  wire logic                     pushbutton_in_n,
  input  wire logic                     pushbutton_driven,
  input  wire pps_pkg::pps_chan_t       chan_enable,
  input  wire pps_pkg::pps_chan_t       power_good,
  input  wire logic                     fault_in,
  input  wire logic                     mode_select_in,
  output logic                          button_status_out_n,
  output logic                          button_status_oe,
  output pps_pkg::pps_chan_t            converter_on,
  output logic                          switched_out_on,
  output logic                          active_discharge,
  output logic                          cpu_reset_n,
  output logic                          fixed_freq,
  output logic                          osc_tick,
  input  wire logic [pps_pkg::ADDR_W-1:0] address,
  input  wire logic                     read,
  input  wire logic                     write,
  input  wire logic [31:0]              writedata,
  input  wire logic [3:0]               byteenable,
  output logic [31:0]                   readdata,
  output logic                          waitrequest
);
  import pps_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  pps_state_t        state;
  logic [13:0]       osc_acc;
  logic [DB_W-1:0]   db_cnt;
  logic              btn_pressed;
  logic [INIT_W-1:0] init_cnt;
  logic              manual;
  pps_chan_t         started;
  logic [RST_W-1:0]  rst_cnt;
  logic [RST_W-1:0]  rst_tc;

  // ****************************************************************
  // decode
  // ****************************************************************
  wire        hold_eff     = power_hold_driven & power_hold_in;
  wire        pb_eff_n     = ~pushbutton_driven | pushbutton_in_n;
  // accumulator keeps the mean tick rate exact; spacing jitters by one clock
  wire [14:0] osc_sum      = {1'b0, osc_acc} + {1'b0, OSC_STEP};
  wire        osc_wrap     = osc_sum >= {1'b0, OSC_MOD};
  wire        db_last      = db_cnt == DB_W'(DEBOUNCE_TICKS - 1);
  wire        enable_req   = hold_eff | btn_pressed;
  wire        go           = (state == ST_RUN) & ~fault_in;
  wire        ready_one    = ~chan_enable.one | (started.one & power_good.one);
  wire        ready_two    = ready_one & (~chan_enable.two | (started.two & power_good.two));
  wire        all_good     = ready_two
                           & (~chan_enable.three | (started.three & power_good.three));
  wire        rst_done     = rst_cnt >= rst_tc;
  wire        timer_run    = go & all_good;
  wire        bus_req      = (read | write) & waitrequest;
  wire        bus_done     = (read | write) & ~waitrequest;
  wire        sel_ctrl     = address == REG_CTRL;
  wire        sel_status   = address == REG_STATUS;

  // started bits stick while running; manual mode drops the power-good gate
  pps_chan_t next_started;
  assign next_started.one   = go & (started.one | chan_enable.one);
  assign next_started.two   = go & (started.two
                            | (chan_enable.two & (manual | ready_one)));
  assign next_started.three = go & (started.three
                            | (chan_enable.three & (manual | ready_two)));

  wire [31:0] status_word = (32'(state) << ST_STATE_LSB)
                          | (32'(manual) << ST_MANUAL)
                          | (32'(btn_pressed) << ST_BUTTON)
                          | (32'(started) << ST_STARTED)
                          | (32'(power_good) << ST_PGOOD)
                          | (32'(cpu_reset_n) << ST_CPU_RUN)
                          | (32'(switched_out_on) << ST_SWITCH)
                          | (32'(fault_in) << ST_FAULT);
  wire [31:0] next_readdata = sel_ctrl   ? {16'h0000, rst_tc}
                            : sel_status ? status_word
                            : 32'h0000_0000;

  pps_state_t next_state;
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_STANDBY: if (enable_req && !fault_in) next_state = ST_INIT;
      ST_INIT:    if (!enable_req) next_state = ST_STANDBY;
                  else if (init_cnt == INIT_LAST) next_state = ST_RUN;
      ST_RUN:     if (!enable_req) next_state = ST_STANDBY;
    endcase
  end

  // ****************************************************************
  // oscillator tick and debounce
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!resetn)
      osc_acc <= 14'h0000;
    else
      osc_acc <= osc_wrap ? 14'(osc_sum - {1'b0, OSC_MOD}) : osc_sum[13:0];
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      db_cnt      <= '0;
      btn_pressed <= 1'b0;
    end
    // release is not filtered: a bounce on release only ends the press early
    else if (pb_eff_n)
    begin
      db_cnt      <= '0;
      btn_pressed <= 1'b0;
    end
    else if (osc_wrap && !btn_pressed)
    begin
      db_cnt      <= db_cnt + DB_W'(1);
      btn_pressed <= db_last;
    end
  end

  // ****************************************************************
  // sequencing
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state    <= ST_STANDBY;
      init_cnt <= '0;
      manual   <= 1'b0;
      started  <= '0;
    end
    else
    begin
      state    <= next_state;
      init_cnt <= (state == ST_INIT) ? init_cnt + INIT_W'(1) : '0;
      if (state == ST_INIT && next_state == ST_RUN)
        manual <= chan_enable == pps_chan_t'(3'b000);
      else if (state == ST_STANDBY)
        manual <= 1'b0;
      started  <= next_started;
    end
  end

  // timer restarts from zero whenever regulation or enable is lost
  always_ff @(posedge clk)
  begin
    if (!resetn || !timer_run)
      rst_cnt <= '0;
    else if (osc_wrap && !rst_done)
      rst_cnt <= rst_cnt + RST_W'(1);
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      button_status_out_n <= 1'b1;
      button_status_oe    <= 1'b0;
      converter_on        <= '0;
      switched_out_on     <= 1'b0;
      active_discharge    <= 1'b1;
      cpu_reset_n         <= 1'b0;
      fixed_freq          <= 1'b0;
      osc_tick            <= 1'b0;
    end
    else
    begin
      button_status_out_n <= ~btn_pressed;
      button_status_oe    <= btn_pressed;
      // gated by go so rails drop in the cycle that discharge rises
      converter_on        <= started & chan_enable & {3{go}};
      switched_out_on     <= go & started.three & power_good.three;
      active_discharge    <= state == ST_STANDBY;
      cpu_reset_n         <= timer_run & rst_done;
      fixed_freq          <= mode_select_in;
      osc_tick            <= osc_wrap;
    end
  end

  // ****************************************************************
  // register bus
  // ****************************************************************
  // one wait cycle on every access; write lands on the release edge
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
      rst_tc      <= RST_TC_RESET;
    end
    else
    begin
      waitrequest <= ~bus_req;
      if (bus_req && read)
        readdata <= next_readdata;
      if (bus_done && write && sel_ctrl)
      begin
        if (byteenable[0])
          rst_tc[7:0] <= writedata[7:0];
        if (byteenable[1])
          rst_tc[15:8] <= writedata[15:8];
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_enable_entry: assert property (state == ST_STANDBY && enable_req && !fault_in
    |=> state == ST_INIT) else $error("enable request did not leave standby");
  a_debounce_len: assert property ($rose(btn_pressed)
    |-> $past(db_cnt) == DB_W'(DEBOUNCE_TICKS - 1)) else $error("debounce too short");
  a_status_follows: assert property ($rose(btn_pressed)
    |=> !button_status_out_n && button_status_oe) else $error("status not driven low");
  a_two_after_one: assert property ($rose(started.two) && !manual
    |-> $past(ready_one)) else $error("channel two started early");
  a_three_after_two: assert property ($rose(started.three) && !manual
    |-> $past(ready_two)) else $error("buck-boost started early");
  a_switch_cause: assert property ($rose(switched_out_on)
    |-> $past(started.three && power_good.three)) else $error("switch on without good");
  a_reset_release: assert property ($rose(cpu_reset_n)
    |-> $past(rst_done && all_good)) else $error("reset released early");
  a_release_off: assert property (state == ST_RUN && !hold_eff && !btn_pressed
    |=> state == ST_STANDBY ##1 active_discharge) else $error("no shutdown");
  a_standby_quiet: assert property (state == ST_STANDBY [*2]
    |-> converter_on == pps_chan_t'(3'b000) && !cpu_reset_n) else $error("standby active");
  a_fault_reset: assert property (fault_in |=> !cpu_reset_n) else $error("reset not held");
  a_pg_loss_clear: assert property (go && !all_good |=> rst_cnt == '0)
    else $error("timer not cleared");
  a_mode_follow: assert property (mode_select_in |=> fixed_freq)
    else $error("mode not applied");
  a_bus_wait: assert property (bus_req |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not one cycle");
  a_off_when_idle: assert property (!go |=> converter_on == pps_chan_t'(3'b000))
    else $error("converter on while not running");
  a_oe_pairs: assert property (button_status_oe == !button_status_out_n)
    else $error("status enable disagrees with status");
  a_manual_ungated: assert property (manual && go && chan_enable.three |=> started.three)
    else $error("manual channel not started");
  a_switch_off: assert property (!power_good.three |=> !switched_out_on)
    else $error("switch on without buck-boost good");
  a_hold_pulldown: assert property (!power_hold_driven && !btn_pressed && state == ST_STANDBY
    |=> state == ST_STANDBY) else $error("undriven hold enabled device");
  a_fault_block: assert property (state == ST_STANDBY && fault_in |=> state == ST_STANDBY)
    else $error("left standby during fault");

  c_full_power_up: cover property ($rose(cpu_reset_n) && !manual);
  c_manual_start: cover property ($rose(started.one) && manual && started.two);
  c_fault_recover: cover property (fault_in ##1 !fault_in [*2] ##1 go);
  c_button_off: cover property (state == ST_RUN ##1 state == ST_STANDBY);
  c_skip_channel: cover property ($rose(started.three) && !chan_enable.two && !manual);

endmodule

// [src/pps_pkg.sv]
/*
  Package for the pushbutton power sequencer: channel carrier, states,
  register map and timing constants.
  Assumes a 10 MHz system clock and a 32-bit Avalon-MM register bus.
*/
package pps_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 100;
  localparam int CLK_KHZ        = 10000;
  localparam int OSC_KHZ        = 1270;
  localparam int DEBOUNCE_US    = 24000;
  localparam int DEBOUNCE_TICKS = (DEBOUNCE_US * OSC_KHZ + 999) / 1000;
  localparam int INIT_NS        = 10000;
  localparam int INIT_CYCLES    = (INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // fractional divider: add OSC_KHZ every clock, wrap at CLK_KHZ
  localparam logic [13:0] OSC_STEP = 14'(OSC_KHZ);
  localparam logic [13:0] OSC_MOD  = 14'(CLK_KHZ);

  localparam int DB_W   = 15;
  localparam int INIT_W = 7;
  localparam int RST_W  = 16;
  localparam logic [INIT_W-1:0] INIT_LAST = INIT_W'(INIT_CYCLES - 1);

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam int          ADDR_W     = 4;
  localparam logic [3:0]  REG_CTRL   = 4'h0;
  localparam logic [3:0]  REG_STATUS = 4'h4;
  localparam logic [15:0] RST_TC_RESET = 16'h0100;

  // status field positions
  localparam int ST_STATE_LSB = 0;
  localparam int ST_MANUAL    = 2;
  localparam int ST_BUTTON    = 3;
  localparam int ST_STARTED   = 4;
  localparam int ST_PGOOD     = 7;
  localparam int ST_CPU_RUN   = 10;
  localparam int ST_SWITCH    = 11;
  localparam int ST_FAULT     = 12;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic one;
    logic two;
    logic three;
  } pps_chan_t;

  typedef enum logic [1:0] {
    ST_STANDBY,
    ST_INIT,
    ST_RUN
  } pps_state_t;

endpackage

// [verif/pps_partner.sv]
/*
  Partner model: processor hold logic and converter power-good ramps.
  Assumes the sequencer's clock and the package channel layout.
*/
`timescale 1ns/1ps
module pps_partner
#(
  parameter int PG_DELAY = 5
)
(
  input  wire logic               clk,
  input  wire pps_pkg::pps_chan_t converter_on,
  input  wire pps_pkg::pps_chan_t pg_drop,
  input  wire logic               cpu_reset_n,
  input  wire logic               button_status_out_n,
  input  wire logic               cpu_keep,
  output pps_pkg::pps_chan_t      power_good,
  output logic                    power_hold_in
);
  import pps_pkg::*;
  int   ramp [3];
  logic armed;
  // ****************************************
  // rails and processor
  // ****************************************
  always @(posedge clk)
  begin
    for (int i = 0; i < 3; i++)
    begin
      // a rail needs time to ramp; good drops at once when switched off
      ramp[i]       <= converter_on[i] ? ramp[i] + 1 : 0;
      power_good[i] <= converter_on[i] && ramp[i] >= PG_DELAY && !pg_drop[i];
    end
    if (!cpu_keep)
      {power_hold_in, armed} <= 2'h0;
    else if (cpu_reset_n && !power_hold_in && !armed)
      power_hold_in <= 1'h1;
    else if (power_hold_in && button_status_out_n)
      armed <= 1'h1;
    else if (armed && !button_status_out_n)
      power_hold_in <= 1'h0;
  end
endmodule

// [verif/pps_sequencer_test.sv]
/*
  Self-checking bench for the power sequencer, with the partner model.
  Assumes pps_pkg and pps_partner; bus reads are checked from a queue.
*/
`timescale 1ns/1ps
module pps_sequencer_test;
  import pps_pkg::*;
  localparam int PG_D = 5;
  logic        clk = 1'h0, resetn = 1'h0, tb_hold = 1'h0, hold_drv = 1'h0, hold;
  logic        btn_n = 1'h1, btn_drv = 1'h0, fault = 1'h0, mode = 1'h0, keep = 1'h0;
  logic        read = 1'h0, write = 1'h0, status_n, sw_on, dis, rst_n, ffreq, tick, waitrequest;
  logic [3:0]  address = 4'h0;
  logic [31:0] writedata = 32'h0, readdata, r;
  logic        oe;
  pps_chan_t   chan = 3'h7, drop = 3'h0, on, pg;
  logic [31:0] rq [$];
  int          fail_count = 0, samples_checked = 0, cyc = 0, ticks = 0, n, c0;
  int          ton [3];

  initial
  begin
    forever #50 clk = ~clk;
  end

  pps_sequencer #(.DEBOUNCE_TICKS(4)) u_pps_sequencer (
    .clk(clk), .resetn(resetn), .power_hold_in(hold | tb_hold), .power_hold_driven(hold_drv),
    .pushbutton_in_n(btn_n), .pushbutton_driven(btn_drv), .chan_enable(chan),
    .power_good(pg), .fault_in(fault), .mode_select_in(mode),
    .button_status_out_n(status_n), .button_status_oe(oe), .converter_on(on),
    .switched_out_on(sw_on), .active_discharge(dis), .cpu_reset_n(rst_n),
    .fixed_freq(ffreq), .osc_tick(tick), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest));

  pps_partner #(.PG_DELAY(PG_D)) u_pps_partner (
    .clk(clk), .converter_on(on), .pg_drop(drop), .cpu_reset_n(rst_n),
    .button_status_out_n(status_n), .cpu_keep(keep), .power_good(pg), .power_hold_in(hold));

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
      fail_count++;
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic timeout;
    $display("ERROR wait expected done seen timeout");
    fail_count++;
    finish_test();
  endtask

  // ****************************************
  // monitor: read data against queued notes
  // ****************************************
  always @(posedge clk)
  begin
    cyc   <= cyc + 1;
    ticks <= ticks + int'(tick);
    for (int i = 0; i < 3; i++)
      if (on[i] !== 1'h1) ton[i] <= 0;
      else if (ton[i] == 0) ton[i] <= cyc;
    if (read && waitrequest === 1'h0)
      check("readdata", readdata, rq.size() ? rq.pop_front() : 32'hdead);
  end

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    if (!w) rq.push_back(d);
    address   <= a;
    writedata <= d;
    write     <= w;
    read      <= !w;
    @(posedge clk);
    for (n = 0; n < 20 && waitrequest !== 1'h0; n++) @(posedge clk);
    if (n == 20) timeout();
    read  <= 1'h0;
    write <= 1'h0;
    @(posedge clk);
  endtask

  function automatic bit cond(int k);
    case (k)
      0: return status_n === 1'h0;
      1: return rst_n === 1'h1;
      default: return dis === 1'h1;
    endcase
  endfunction

  task automatic wt(int k);
    for (n = 0; n < 3000 && !cond(k); n++) @(posedge clk);
    if (n == 3000) timeout();
  endtask

  task automatic cycles(int m);
    repeat (m) @(posedge clk);
  endtask

  // ****************************************
  // stimulus
  // ****************************************
  initial
  begin
    void'($urandom(59918));
    repeat (3) @(posedge clk);
    resetn <= 1'h1;
    check("cpu_reset_n", rst_n, 1'h0);
    check("discharge", dis, 1'h1);
    check("converter_on", on, 3'h0);
    @(posedge clk);
    bus(1'h0, REG_CTRL, 32'h100);
    bus(1'h0, REG_STATUS, 32'h0);
    bus(1'h1, REG_STATUS, 32'hffffffff);
    bus(1'h0, 4'h8, 32'h0);
    bus(1'h1, REG_CTRL, 32'h8);
    bus(1'h0, REG_CTRL, 32'h8);
    c0 = ticks;
    cycles(1000);
    check("osc ticks", 32'(ticks - c0), 32'h7f);
    $display("test registers done");
    tb_hold <= 1'h1;
    btn_n   <= 1'h0;
    cycles(60);
    check("status undriven", status_n, 1'h1);
    check("status oe idle", oe, 1'h0);
    check("discharge", dis, 1'h1);
    tb_hold  <= 1'h0;
    hold_drv <= 1'h1;
    btn_drv  <= 1'h1;
    cycles(10);
    btn_n <= 1'h1;
    cycles(40);
    check("status glitch", status_n, 1'h1);
    $display("test undriven and glitch done");
    keep  <= 1'h1;
    btn_n <= 1'h0;
    c0 = cyc;
    wt(0);
    check("debounce span", 32'(cyc - c0 >= 20), 32'h1);
    check("status oe", oe, 1'h1);
    wt(1);
    check("switched out", sw_on, 1'h1);
    check("converter_on", on, 3'h7);
    check("two after one good", 32'(ton[1] - ton[2] > PG_D), 32'h1);
    check("three after two good", 32'(ton[0] - ton[1] > PG_D), 32'h1);
    check("reset interval", 32'(cyc - ton[0] >= 60), 32'h1);
    btn_drv <= 1'h0;
    cycles(20);
    check("held on", {dis, on}, 4'h7);
    $display("test button power-up done");
    drop <= 3'h2;
    cycles(4);
    check("reset on pg loss", rst_n, 1'h0);
    drop <= 3'h0;
    wt(1);
    check("converter_on", on, 3'h7);
    fault <= 1'h1;
    cycles(4);
    check("fault state", {rst_n, on}, 4'h0);
    fault <= 1'h0;
    wt(1);
    check("converter_on", on, 3'h7);
    $display("test faults done");
    btn_drv <= 1'h1;
    wt(0);
    cycles(5);
    btn_drv <= 1'h0;
    wt(2);
    check("off state", {rst_n, sw_on, on}, 5'h0);
    $display("test power-down done");
    keep    <= 1'h0;
    chan    <= 3'h5;
    tb_hold <= 1'h1;
    wt(1);
    check("skip two", on, 3'h5);
    check("three after one good", 32'(ton[0] - ton[2] > PG_D), 32'h1);
    tb_hold <= 1'h0;
    wt(2);
    $display("test skip done");
    chan    <= 3'h0;
    tb_hold <= 1'h1;
    cycles(120);
    for (int k = 0; k < 5; k++)
    begin
      r = (k == 4) ? 32'h7 : $urandom;
      chan <= r[2:0];
      mode <= r[3];
      cycles(3);
      check("manual on", on, r[2:0]);
      check("fixed freq", ffreq, r[3]);
    end
    $display("test manual done");
    finish_test();
  end
endmodule
